/* src/afe_clamp_pkg.sv */
package afe_clamp_pkg;

   // Colour select codes for the coefficient multiplexer
   typedef enum logic [1:0] {
      COLOUR_RED   = 2'h0,
      COLOUR_GREEN = 2'h1,
      COLOUR_BLUE  = 2'h2,
      COLOUR_MONO  = 2'h3
   } colour_t;

   // One gain/offset coefficient pair
   typedef struct packed {
      logic [7:0] gain;
      logic [7:0] offset;
   } coeff_t;

   // Register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_RED    = 4'h1;
   localparam logic [3:0] REG_GREEN  = 4'h2;
   localparam logic [3:0] REG_BLUE   = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;

   // Control register field positions
   localparam int CTRL_CLAMP_BIT  = 0;
   localparam int CTRL_CDS_BIT    = 1;
   localparam int CTRL_MONO_BIT   = 2;
   localparam int CTRL_COLOUR_LSB = 3;
   localparam int CTRL_REFPOS_LSB = 5;

   // Reset values
   localparam logic [15:0] COEFF_RESET = 16'h0000;
   localparam logic        CDS_RESET   = 1'b1;
   localparam logic        CLAMP_RESET = 1'b0;
   localparam logic        MONO_RESET  = 1'b0;

   // Timing counts in master clock cycles
   localparam int REF_BASE_DELAY = 1;
   localparam int NIBBLES        = 4;

endpackage : afe_clamp_pkg

/* src/afe_sample_clamp_control.sv */
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: Each 16-bit result leaves as four nibbles on a 4-bit bus.
// R2: Controller writes configuration and per-colour coefficients; channel applies them.
// R3: Monochrome applies one fixed coefficient pair to every pixel.
// R4: Colour mode picks red, green or blue pair by two-bit select.
// R5: Controller changes colour with one select write per new line.
// R6: Clamp pulse comes from clock and strobe, only when clamp enabled.
// R7: Clamp enable captured on clock edge within strobe, governs next reset.
// R8: Two-bit reference position shifts the clamp pulse timing.
// R9: Clamping works with correlated or non-correlated sampling.
// R10: Sampling-mode bit one selects correlated sampling; default after reset.
// R11: Reference position moves the reset-level sampling instant.
// R12: Non-correlated mode samples reference pin together with video sample.
// R13: Clamp enable resets low; colour select resets to first code.
module afe_sample_clamp_control (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic [3:0]            regAddr,
   input  wire logic [15:0]           regWdata,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   output logic      [15:0]           regRdata,
   input  wire logic                  sampleStrobe,
   input  wire logic [15:0]           adcResult,
   input  wire logic                  adcValid,
   output logic      [3:0]            nibbleOut,
   output logic                       nibbleValid,
   output logic                       clampPulse,
   output logic                       resetSample,
   output logic                       videoSample,
   output logic                       refPinSelect,
   output afe_clamp_pkg::coeff_t      activeCoeff
);

   // Configuration state
   logic                   clampEnable;
   logic                   corrSampling;
   logic                   monoMode;
   afe_clamp_pkg::colour_t colourSel;
   logic [1:0]             refPosition;
   afe_clamp_pkg::coeff_t  coeffSet [3];

   // Timing state
   logic       strobeDly;
   logic       clampArmed;
   logic [2:0] refCount;
   logic       refActive;
   logic [15:0] shiftWord;
   logic [1:0]  nibbleCount;
   logic        shifting;

   // Coefficient lookup for a colour code
   function automatic afe_clamp_pkg::coeff_t pick(
      input afe_clamp_pkg::colour_t c,
      input logic                   mono
   );
      if (mono || c == afe_clamp_pkg::COLOUR_MONO) begin
         pick = coeffSet[0];
      end else begin
         pick = coeffSet[c];
      end
   endfunction : pick

   // Control register writes
   // R2: register writes applied
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // R13: reset defaults
         clampEnable  <= afe_clamp_pkg::CLAMP_RESET;
         // R10: correlated default
         corrSampling <= afe_clamp_pkg::CDS_RESET;
         monoMode     <= afe_clamp_pkg::MONO_RESET;
         colourSel    <= afe_clamp_pkg::COLOUR_RED;
         refPosition  <= 2'h0;
      end else if (regWrite && regAddr == afe_clamp_pkg::REG_CTRL) begin
         clampEnable  <= regWdata[afe_clamp_pkg::CTRL_CLAMP_BIT];
         corrSampling <= regWdata[afe_clamp_pkg::CTRL_CDS_BIT];
         monoMode     <= regWdata[afe_clamp_pkg::CTRL_MONO_BIT];
         colourSel    <= afe_clamp_pkg::colour_t'(
                            regWdata[afe_clamp_pkg::CTRL_COLOUR_LSB +: 2]);
         refPosition  <= regWdata[afe_clamp_pkg::CTRL_REFPOS_LSB +: 2];
      end
   end

   // Coefficient register writes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < 3; i++) begin
            coeffSet[i] <= afe_clamp_pkg::COEFF_RESET;
         end
      end else if (regWrite) begin
         if (regAddr == afe_clamp_pkg::REG_RED) begin
            coeffSet[0] <= regWdata;
         end else if (regAddr == afe_clamp_pkg::REG_GREEN) begin
            coeffSet[1] <= regWdata;
         end else if (regAddr == afe_clamp_pkg::REG_BLUE) begin
            coeffSet[2] <= regWdata;
         end
      end
   end

   // Register read port, data one cycle after strobe
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         regRdata <= 16'h0000;
      end else if (!regRead) begin
         regRdata <= 16'h0000;
      end else if (regAddr == afe_clamp_pkg::REG_CTRL) begin
         regRdata <= {9'h000, refPosition, colourSel, monoMode,
                      corrSampling, clampEnable};
      end else if (regAddr == afe_clamp_pkg::REG_RED) begin
         regRdata <= coeffSet[0];
      end else if (regAddr == afe_clamp_pkg::REG_GREEN) begin
         regRdata <= coeffSet[1];
      end else if (regAddr == afe_clamp_pkg::REG_BLUE) begin
         regRdata <= coeffSet[2];
      end else if (regAddr == afe_clamp_pkg::REG_STATUS) begin
         regRdata <= {13'h0000, shifting, refActive, clampArmed};
      end else begin
         regRdata <= 16'h0000;
      end
   end

   // Coefficient pair driven to the channel
   // R3: mono fixed pair
   // R4: colour select
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         activeCoeff <= afe_clamp_pkg::COEFF_RESET;
      end else begin
         activeCoeff <= pick(colourSel, monoMode);
      end
   end

   // Clamp enable capture inside strobe
   // R7: capture on strobe edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         strobeDly  <= 1'b0;
         clampArmed <= 1'b0;
      end else begin
         strobeDly <= sampleStrobe;
         if (sampleStrobe && !strobeDly) begin
            clampArmed <= clampEnable;
         end
      end
   end

   // Reset-level timing after strobe end, delayed by reference position
   // R8: shifted clamp position
   // R11: reset sample instant
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         refCount  <= 3'h0;
         refActive <= 1'b0;
      end else if (!sampleStrobe && strobeDly) begin
         refCount  <= 3'(afe_clamp_pkg::REF_BASE_DELAY) + 3'(refPosition);
         refActive <= 1'b0;
      end else if (refCount != 3'h0) begin
         refCount  <= refCount - 3'h1;
         refActive <= (refCount == 3'h1);
      end else begin
         refActive <= 1'b0;
      end
   end

   // Clamp pulse and sampling clocks
   // R6: gated clamp pulse
   // R9: clamp in both modes
   // R12: reference with video
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         clampPulse   <= 1'b0;
         resetSample  <= 1'b0;
         videoSample  <= 1'b0;
         refPinSelect <= 1'b0;
      end else begin
         clampPulse   <= refActive && clampArmed;
         videoSample  <= sampleStrobe && !strobeDly;
         refPinSelect <= !corrSampling;
         resetSample  <= corrSampling ? refActive
                                      : (sampleStrobe && !strobeDly);
      end
   end

   // Nibble serialiser, high nibble first
   // R1: four nibbles out
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shiftWord   <= 16'h0000;
         nibbleCount <= 2'h0;
         shifting    <= 1'b0;
         nibbleOut   <= 4'h0;
         nibbleValid <= 1'b0;
      end else if (adcValid) begin
         shiftWord   <= {adcResult[11:0], 4'h0};
         nibbleOut   <= adcResult[15:12];
         nibbleValid <= 1'b1;
         nibbleCount <= 2'h3;
         shifting    <= 1'b1;
      end else if (shifting) begin
         nibbleOut   <= shiftWord[15:12];
         shiftWord   <= {shiftWord[11:0], 4'h0};
         nibbleCount <= nibbleCount - 2'h1;
         shifting    <= (nibbleCount != 2'h1);
         nibbleValid <= 1'b1;
      end else begin
         nibbleValid <= 1'b0;
      end
   end

   // R7: strobe capture
   capture_a: assert property (@(posedge clk_sys) disable iff (srst) // R7
      (sampleStrobe && !strobeDly) |=> (clampArmed == $past(clampEnable)))
      else $error("clamp enable not captured at strobe");

   // R6: gated pulse
   clamp_gate_a: assert property (@(posedge clk_sys) disable iff (srst) // R6
      clampPulse |-> $past(clampArmed))
      else $error("clamp pulse without enable");

   // R8: position delay
   ref_delay_a: assert property (@(posedge clk_sys) disable iff (srst) // R8
      (!sampleStrobe && strobeDly && refPosition == 2'h0) |=> ##1 refActive)
      else $error("reference timing wrong");

   // R13: reset values
   reset_val_a: assert property (@(posedge clk_sys) // R13
      $past(srst) |-> (!clampEnable && colourSel == afe_clamp_pkg::COLOUR_RED
                       && corrSampling))
      else $error("reset defaults wrong");

   // R3: mono pair
   mono_pair_a: assert property (@(posedge clk_sys) disable iff (srst) // R3
      ($past(monoMode) && !$past(srst, 1)) |-> activeCoeff == $past(coeffSet[0]))
      else $error("mono coefficients wrong");

   // R4: colour pair
   colour_pair_a: assert property (@(posedge clk_sys) disable iff (srst) // R4
      (!monoMode && colourSel == afe_clamp_pkg::COLOUR_GREEN)
      |=> activeCoeff == $past(coeffSet[1]))
      else $error("colour coefficients wrong");

   // R1: nibble burst
   nibble_run_a: assert property (@(posedge clk_sys) disable iff (srst) // R1
      adcValid |=> nibbleValid[*4])
      else $error("nibble burst short");

   // R12: reference sample
   noncds_a: assert property (@(posedge clk_sys) disable iff (srst) // R12
      (!corrSampling && sampleStrobe && !strobeDly) |=> (resetSample
                                                         && videoSample))
      else $error("reference not sampled with video");

endmodule : afe_sample_clamp_control

`default_nettype wire

/* verif/scan_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl_model (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        go,
   input  wire logic [15:0] word,
   output logic             sampleStrobe,
   output logic      [15:0] adcResult,
   output logic             adcValid,
   input  wire logic [3:0]  nibbleOut,
   input  wire logic        nibbleValid,
   output logic      [15:0] gathered,
   output logic      [3:0]  nibCount
);
   logic [1:0] hiLeft;

   // Strobe held two cycles, result offered once; idle data inverted
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hiLeft    <= 2'h0;
         adcValid  <= 1'b0;
         adcResult <= 16'hFFFF;
      end else begin
         hiLeft    <= go ? 2'h2 : (hiLeft != 2'h0 ? hiLeft - 2'h1 : 2'h0);
         adcValid  <= go;
         adcResult <= go ? word : ~adcResult;
      end
   end
   assign sampleStrobe = (hiLeft != 2'h0);

   always_ff @(posedge clk_sys) begin
      if (srst || go) begin
         gathered <= 16'h0000;
         nibCount <= 4'h0;
      end else if (nibbleValid) begin
         gathered <= {gathered[11:0], nibbleOut};
         nibCount <= nibCount + 4'h1;
      end
   end
endmodule : scan_ctrl_model

`default_nettype wire

/* verif/afe_sample_clamp_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module afe_sample_clamp_control_tb;
   logic clk_sys, srst, regWrite, regRead, go, strobe, adcValid;
   logic clampPulse, resetSample, videoSample, refPinSelect, nibbleValid;
   logic [3:0]  regAddr, nibbleOut, nibCount;
   logic [15:0] regWdata, regRdata, word, adcResult, gathered, rd;
   afe_clamp_pkg::coeff_t activeCoeff;
   int errTotal, checks, cycles, cyc, clampAt, clampCnt, together, at0;
   int rsAt;
   logic prevStrobe;
   logic [15:0] cv [3] = '{16'h11A2, 16'h22B3, 16'h33C4};

   afe_sample_clamp_control uut (.clk_sys(clk_sys), .srst(srst),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .sampleStrobe(strobe),
      .adcResult(adcResult), .adcValid(adcValid), .nibbleOut(nibbleOut),
      .nibbleValid(nibbleValid), .clampPulse(clampPulse),
      .resetSample(resetSample), .videoSample(videoSample),
      .refPinSelect(refPinSelect), .activeCoeff(activeCoeff));
   scan_ctrl_model partner (.clk_sys(clk_sys), .srst(srst), .go(go),
      .word(word), .sampleStrobe(strobe), .adcResult(adcResult),
      .adcValid(adcValid), .nibbleOut(nibbleOut),
      .nibbleValid(nibbleValid), .gathered(gathered), .nibCount(nibCount));

   // Clock and run limit
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= srst ? 0 : cycles + 1;
      if (cycles == 5000) begin
         errTotal = errTotal + 1;
         endSim();
      end
   end

   // Pulse timing relative to strobe rise
   always @(posedge clk_sys) begin
      prevStrobe <= srst ? 1'b0 : strobe;
      if (srst) begin
         cyc <= 0;
         clampCnt <= 0;
         together <= 0;
         rsAt <= 0;
      end else if (strobe && !prevStrobe) begin
         cyc <= 0; clampCnt <= 0; together <= 0;
      end else begin
         cyc <= cyc + 1;
         if (clampPulse) begin
            clampCnt <= clampCnt + 1; clampAt <= cyc;
         end
         if (resetSample && videoSample) together <= together + 1;
         if (resetSample) rsAt <= cyc;
      end
   end

   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         errTotal = errTotal + 1;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a; regWdata <= d; regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rdReg(logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a; regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rdReg

   function automatic logic [15:0] ctl(logic cl, logic correlated_sampling_enable, logic mono,
                                       logic [1:0] col, logic [1:0] rp);
      return {9'h000, rp, col, mono, correlated_sampling_enable, cl};
   endfunction : ctl

   task automatic pix(logic [15:0] w);
      @(posedge clk_sys);
      go <= 1'b1; word <= w;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
   endtask : pix

   task automatic endSim();
      if (errTotal == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : endSim

   initial begin
      {regWrite, regRead, go} = 3'h0;
      {regAddr, regWdata, word} = 36'h0;
      {errTotal, checks} = '0;
      srst = 1'b1;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rdReg(4'h0, rd); chk("ctrl reset", rd, 16'h0002);
      chk("ref pin", {15'h0, refPinSelect}, 16'h0000);
      rdReg(4'hF, rd); chk("unmapped", rd, 16'h0000);
      pix(16'hA5C3);
      chk("no clamp", 16'(clampCnt), 16'h0000);
      chk("nibbles", gathered, 16'hA5C3);
      chk("nib count", {12'h0, nibCount}, 16'h0004);
      for (int k = 0; k < 3; k++) begin
         wr(4'(k + 1), cv[k]);
         rdReg(4'(k + 1), rd); chk("coeff reg", rd, cv[k]);
      end
      // One select write per colour line
      for (int c = 0; c < 4; c++) begin
         wr(4'h0, ctl(1'b0, 1'b1, 1'b0, 2'(c), 2'h0));
         repeat (2) @(posedge clk_sys);
         #1 chk("colour coeff", activeCoeff, cv[c % 3]);
      end
      wr(4'h0, ctl(1'b0, 1'b1, 1'b1, 2'h2, 2'h0));
      pix(16'h0F0F);
      chk("mono coeff", activeCoeff, cv[0]);
      for (int r = 0; r < 4; r++) begin
         wr(4'h0, ctl(1'b1, 1'b1, 1'b0, 2'h0, 2'(r)));
         pix(16'h1234 + 16'(r));
         if (r == 0) at0 = clampAt;
         chk("clamp count", 16'(clampCnt), 16'h0001);
         chk("clamp shift", 16'(clampAt - at0), 16'(r));
         chk("clamp near", 16'(at0), 16'h0004);
         chk("reset instant", 16'(rsAt), 16'(4 + r));
      end
      wr(4'h0, ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0));
      pix(16'hFEDC);
      chk("ref pin", {15'h0, refPinSelect}, 16'h0001);
      chk("same instant", 16'(together), 16'h0001);
      chk("clamp noncds", 16'(clampCnt), 16'h0001);
      chk("noncds nibbles", gathered, 16'hFEDC);
      chk("noncds reset", 16'(rsAt), 16'h0000);
      rdReg(4'h4, rd); chk("status", rd, 16'h0001);
      endSim();
   end
endmodule : afe_sample_clamp_control_tb

`default_nettype wire
